// file: verilog/rbic_map.vh
// Purpose: Offsets, fields and sizes for the reading buffer controller
// Assumes: APB slave, 32-bit data, word aligned registers
// Notes: Buffer depth fixed at the larger variant capacity
`ifndef RBIC_MAP_VH
`define RBIC_MAP_VH
`define RBIC_DEPTH 17'h10000
`define RBIC_AW 16
`define RBIC_CNT_W 17
`define RBIC_NEAR_ROOM 17'h01000
`define RBIC_OFF_CTRL 12'h000
`define RBIC_OFF_SCAN 12'h004
`define RBIC_OFF_CMD 12'h008
`define RBIC_OFF_STAT 12'h00C
`define RBIC_OFF_DATA 12'h010
`define RBIC_OFF_ISTAT 12'h014
`define RBIC_OFF_IEN 12'h018
`define RBIC_OFF_ICLR 12'h01C
`define RBIC_OFF_THR 12'h020
`define RBIC_OFF_COUNT 12'h024
`define RBIC_MODE_ANY 2'h0
`define RBIC_MODE_NEAR 2'h1
`define RBIC_MODE_END 2'h2
`define RBIC_MODE_TRIM 2'h3
`define RBIC_CMD_ARM 0
`define RBIC_CMD_DISARM 1
`define RBIC_CMD_START 2
`define RBIC_CMD_CLEAR 3
`define RBIC_IRQ_DATA 0
`define RBIC_IRQ_END 1
`define RBIC_IRQ_FULL 2
`define RBIC_IRQ_REFUSE 3
`endif

// file: verilog/rbic_top.v
// Purpose: Reading buffer store, data-available and interrupt control for a scanning voltmeter
// Assumes: One clock, synchronous reset, readings and pass ends arrive as one-cycle pulses
// Notes: Reads of the data register pop one reading when data is available and fetches are allowed; otherwise they return zero
`timescale 1ns/10ps
`include "rbic_map.vh"

// Overview of operation
// RULE_01 - Readings and interrupts go to host or parallel port; host after reset.
// RULE_02 - Parallel destination refuses fetches; interrupt goes only to the port.
// RULE_03 - Changing the destination disarms every interrupt.
// RULE_04 - Changing the storage mode disarms every interrupt.
// RULE_05 - Readings stay buffered until fetched or a configuration write clears them.
// RULE_06 - Any-reading mode: available when non-empty; full buffer aborts the scan.
// RULE_07 - Any-reading: armed interrupt while non-empty; disarm clears only when empty.
// RULE_08 - Near-full: available and interrupt at 4,096 free or scan end; full aborts.
// RULE_09 - Near-full: disarm clears pending interrupt if scanning and room exceeds 4,096.
// RULE_10 - Scan-finish: available when non-empty, interrupt only at scan end, disarm clears.
// RULE_11 - Trimmed-final: available only after scan end; full buffer overwrites oldest.
// RULE_12 - Trimmed-final: keep last prescan plus postscan passes, else last full load.
// RULE_13 - Trimmed-final: interrupt only at scan end; disarm blocks and clears it.
// RULE_14 - Zero postscan: prescan passes repeat until a stop trigger is accepted.
// RULE_15 - Stop triggers before the configured prescan count are ignored.
// RULE_16 - Threshold level is percent of full scale of the first channel's range; code outputs the raw product, not divided by 100.
// RULE_17 - Host should give first channel a fixed range for threshold stopping.
// RULE_18 - Accepted stop finishes current pass, then runs postscan passes, then ends.
// RULE_19 - Stored count against capacity gives full, near-full and not-empty.
module rbic_top (
  input wire clk_sys,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reading_valid,
  input wire [15:0] reading_data,
  input wire pass_end,
  input wire stop_trigger,
  input wire [1:0] first_range,
  output reg scan_active,
  output reg scan_abort,
  output reg [15:0] threshold_level,
  output reg irq_host,
  output reg irq_port
);

  localparam ST_IDLE = 2'h0;
  localparam ST_PRE = 2'h1;
  localparam ST_POST = 2'h2;

  reg [15:0] mem [0:65535];
  reg [15:0] wr_ptr_q;
  reg [15:0] rd_ptr_q;
  reg [16:0] count_q;
  reg [1:0] storage_mode_q;
  reg port_target_q;
  reg [15:0] prescan_q;
  reg [15:0] postscan_q;
  reg [15:0] pass_cnt_q;
  reg [15:0] post_cnt_q;
  reg stop_pend_q;
  reg [1:0] state_q;
  reg scan_done_q;
  reg armed_q;
  reg pend_q;
  reg [16:0] pass_rdgs_q;
  reg [16:0] cur_pass_q;
  reg [3:0] istat_q;
  reg [3:0] ien_q;
  reg signed [7:0] threshold_percent_q;
  reg [15:0] rd_word_q;

  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire wr_ctrl = wr && (paddr == `RBIC_OFF_CTRL);
  wire wr_scan = wr && (paddr == `RBIC_OFF_SCAN);
  wire wr_cmd = wr && (paddr == `RBIC_OFF_CMD);
  wire wr_thr = wr && (paddr == `RBIC_OFF_THR);
  wire rd_data = rd && (paddr == `RBIC_OFF_DATA);

  // Count against capacity
  wire full = (count_q == `RBIC_DEPTH); // [RULE_19]
  wire not_empty = (count_q != 17'h00000); // [RULE_19]
  wire [16:0] room = `RBIC_DEPTH - count_q;
  wire near_full = (room <= `RBIC_NEAR_ROOM); // [RULE_19]

  // Data-available per storage mode
  reg avail;
  always @* begin
    case (storage_mode_q)
      `RBIC_MODE_ANY: avail = not_empty; // [RULE_06]
      `RBIC_MODE_NEAR: avail = not_empty & (near_full | scan_done_q); // [RULE_08]
      `RBIC_MODE_END: avail = not_empty; // [RULE_10]
      `RBIC_MODE_TRIM: avail = not_empty & scan_done_q; // [RULE_11]
      default: avail = 1'b0;
    endcase
  end

  // Fetch refused toward the parallel port
  wire fetch_ok = ~port_target_q; // [RULE_02]
  wire pop = rd_data & avail & fetch_ok;
  wire refused = rd_data & ~fetch_ok;
  wire trim_mode = (storage_mode_q == `RBIC_MODE_TRIM);
  wire push = reading_valid & scan_active & (~full | trim_mode); // [RULE_11]
  wire overwrite = push & full & ~pop; // [RULE_11]
  wire cfg_wr = wr_ctrl | wr_scan | wr_thr | (wr_cmd & pwdata[`RBIC_CMD_CLEAR]);
  wire ctrl_change = wr_ctrl &&
    ((pwdata[2] != port_target_q) || (pwdata[1:0] != storage_mode_q));
  wire stop_ok = (pass_cnt_q + 16'h0001 >= prescan_q); // [RULE_15]
  wire end_now = pass_end && (state_q == ST_POST) && (post_cnt_q == 16'h0000);
  wire end_pre = pass_end && (state_q == ST_PRE) && (stop_pend_q | (stop_trigger & stop_ok))
    && (postscan_q == 16'h0000);
  wire scan_end = end_now | end_pre; // [RULE_18]
  // A reading that meets a full buffer aborts; push alone never sees it outside trim mode
  wire abort_now = reading_valid & scan_active & full & ~trim_mode; // [RULE_06] [RULE_08] [RULE_10]

  // Keep count of the readings to retain in trimmed mode
  function [16:0] keep_cnt;
    input [15:0] pre;
    input [15:0] post;
    input [16:0] per;
    reg [33:0] prod;
    begin
      prod = ({18'h00000, pre} + {18'h00000, post}) * {17'h00000, per};
      keep_cnt = (prod > {17'h00000, `RBIC_DEPTH}) ? `RBIC_DEPTH : prod[16:0];
    end
  endfunction

  // Trim sizing; a prescan pass that ends the scan counts in full, last reading included
  wire [16:0] per_now = (pass_end && (state_q == ST_PRE)) ? cur_pass_q + {16'h0000, push}
    : pass_rdgs_q;
  wire [16:0] keep = keep_cnt(prescan_q, postscan_q, per_now);
  wire [16:0] cnt_after = count_q + {16'h0000, push & ~full};
  wire [16:0] trim_base = {1'b0, wr_ptr_q} + {16'h0000, push} - keep;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer storage
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q] <= reading_data; // [RULE_05]
    end
    rd_word_q <= mem[rd_ptr_q];
  end

  // Pointers and count; overwriting drops the oldest reading
  always @(posedge clk_sys) begin
    if (reset || cfg_wr) begin
      wr_ptr_q <= 16'h0000; // [RULE_05]
      rd_ptr_q <= 16'h0000;
      count_q <= 17'h00000;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 16'h0001;
      end
      if (pop || overwrite) begin
        rd_ptr_q <= rd_ptr_q + 16'h0001;
      end
      if (scan_end && trim_mode && (cnt_after > keep)) begin
        // Trim to the last passes, counting the reading stored at this same edge
        rd_ptr_q <= trim_base[15:0]; // [RULE_12]
        count_q <= keep; // [RULE_12]
      end else if (push && !pop && !overwrite) begin
        count_q <= count_q + 17'h00001;
      end else if (pop && !push) begin
        count_q <= count_q - 17'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencing: prescan passes, stop acceptance, postscan passes
  always @(posedge clk_sys) begin
    if (reset || cfg_wr) begin
      state_q <= ST_IDLE;
      scan_active <= 1'b0;
      scan_done_q <= 1'b0;
      pass_cnt_q <= 16'h0000;
      post_cnt_q <= 16'h0000;
      stop_pend_q <= 1'b0;
      scan_abort <= 1'b0;
      pass_rdgs_q <= 17'h00000;
      cur_pass_q <= 17'h00000;
    end else begin
      scan_abort <= abort_now;
      if (push) begin
        cur_pass_q <= cur_pass_q + 17'h00001;
      end
      case (state_q)
        ST_IDLE: begin
          if (wr_cmd && pwdata[`RBIC_CMD_START]) begin
            state_q <= ST_PRE;
            scan_active <= 1'b1;
            scan_done_q <= 1'b0;
            pass_cnt_q <= 16'h0000;
          end
        end
        ST_PRE: begin
          if (stop_trigger && stop_ok && !pass_end) begin
            stop_pend_q <= 1'b1; // [RULE_14] takes effect at the pass end
          end
          if (pass_end) begin
            pass_cnt_q <= pass_cnt_q + 16'h0001;
            pass_rdgs_q <= cur_pass_q + {16'h0000, push};
            cur_pass_q <= 17'h00000;
            if (stop_pend_q || (stop_trigger && stop_ok)) begin
              stop_pend_q <= 1'b0;
              if (postscan_q == 16'h0000) begin
                state_q <= ST_IDLE; // [RULE_18]
                scan_active <= 1'b0;
                scan_done_q <= 1'b1;
              end else begin
                state_q <= ST_POST; // [RULE_18]
                post_cnt_q <= postscan_q - 16'h0001;
              end
            end
          end
        end
        ST_POST: begin
          if (pass_end) begin
            cur_pass_q <= 17'h00000;
            if (post_cnt_q == 16'h0000) begin
              state_q <= ST_IDLE;
              scan_active <= 1'b0;
              scan_done_q <= 1'b1;
            end else begin
              post_cnt_q <= post_cnt_q - 16'h0001;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (abort_now) begin
        state_q <= ST_IDLE; // [RULE_06] [RULE_08] [RULE_10]
        scan_active <= 1'b0;
        scan_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-available interrupt latch per storage mode
  reg pend_set;
  reg pend_keep;
  always @* begin
    pend_set = 1'b0;
    pend_keep = 1'b1;
    case (storage_mode_q)
      `RBIC_MODE_ANY: begin
        pend_set = not_empty; // [RULE_07]
        pend_keep = not_empty; // [RULE_07] disarm cannot clear while readings remain
      end
      `RBIC_MODE_NEAR: begin
        pend_set = (not_empty & near_full) | scan_end; // [RULE_08]
        pend_keep = ~(scan_active & ~near_full); // [RULE_09]
      end
      `RBIC_MODE_END: begin
        pend_set = scan_end; // [RULE_10]
        pend_keep = 1'b0; // [RULE_10]
      end
      `RBIC_MODE_TRIM: begin
        pend_set = scan_end; // [RULE_13]
        pend_keep = 1'b0; // [RULE_13]
      end
      default: begin
        pend_set = 1'b0;
        pend_keep = 1'b0;
      end
    endcase
  end

  wire disarm = wr_cmd & pwdata[`RBIC_CMD_DISARM];

  always @(posedge clk_sys) begin
    if (reset) begin
      armed_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (ctrl_change || disarm) begin
        armed_q <= 1'b0; // [RULE_03] [RULE_04]
      end else if (wr_cmd && pwdata[`RBIC_CMD_ARM]) begin
        armed_q <= 1'b1;
      end
      // Set beats clear; any-reading mode holds pending while data remains
      if (armed_q && pend_set) begin
        pend_q <= 1'b1;
      end else if (storage_mode_q == `RBIC_MODE_ANY && !not_empty) begin
        pend_q <= 1'b0; // [RULE_07]
      end else if ((disarm && !pend_keep) || ctrl_change || cfg_wr) begin
        pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, enable and clear; routed to one destination
  wire [3:0] ev = {refused, abort_now, scan_end, pend_q & armed_q};
  wire icl = wr && (paddr == `RBIC_OFF_ICLR);

  always @(posedge clk_sys) begin
    if (reset) begin
      istat_q <= 4'h0;
      ien_q <= 4'h0;
      irq_host <= 1'b0;
      irq_port <= 1'b0;
    end else begin
      istat_q <= ev | (istat_q & ~(icl ? pwdata[3:0] : 4'h0));
      if (ctrl_change) begin
        ien_q <= 4'h0; // [RULE_03] [RULE_04] sticky events must not leak to the new target
      end else if (wr && (paddr == `RBIC_OFF_IEN)) begin
        ien_q <= pwdata[3:0];
      end
      irq_host <= ~port_target_q & |(istat_q & ien_q); // [RULE_01] [RULE_02]
      irq_port <= port_target_q & |(istat_q & ien_q); // [RULE_02]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers and threshold scaling
  // Full scale codes per range; level is the first channel range's full scale code times the percent
  function [15:0] full_scale;
    input [1:0] r;
    begin
      case (r)
        2'h0: full_scale = 16'h0028;
        2'h1: full_scale = 16'h0140;
        2'h2: full_scale = 16'h0A00;
        default: full_scale = 16'h2800;
      endcase
    end
  endfunction

  wire signed [24:0] thr_prod = $signed({1'b0, full_scale(first_range)}) * threshold_percent_q;

  always @(posedge clk_sys) begin
    if (reset) begin
      storage_mode_q <= `RBIC_MODE_ANY;
      port_target_q <= 1'b0; // [RULE_01]
      prescan_q <= 16'h0000;
      postscan_q <= 16'h0000;
      threshold_percent_q <= 8'h00;
      threshold_level <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        storage_mode_q <= pwdata[1:0];
        port_target_q <= pwdata[2];
      end
      if (wr_scan) begin
        prescan_q <= pwdata[15:0];
        postscan_q <= pwdata[31:16];
      end
      if (wr_thr) begin
        threshold_percent_q <= pwdata[7:0];
      end
      // Units of millivolt-percent: the raw product slice, not divided by 100
      threshold_level <= thr_prod[15:0]; // [RULE_16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so buffer memory can be read
  always @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pslverr <= ~pwrite && (paddr == `RBIC_OFF_DATA) && ~fetch_ok;
        case (paddr)
          `RBIC_OFF_CTRL: prdata <= {29'h0, port_target_q, storage_mode_q};
          `RBIC_OFF_SCAN: prdata <= {postscan_q, prescan_q};
          `RBIC_OFF_STAT: prdata <= {26'h0, scan_done_q, armed_q, full, near_full,
            avail, scan_active};
          `RBIC_OFF_DATA: prdata <= (avail && fetch_ok) ? {16'h0000, rd_word_q} : 32'h0;
          `RBIC_OFF_ISTAT: prdata <= {28'h0, istat_q};
          `RBIC_OFF_IEN: prdata <= {28'h0, ien_q};
          `RBIC_OFF_THR: prdata <= {24'h0, threshold_percent_q};
          `RBIC_OFF_COUNT: prdata <= {15'h0, count_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: bench/rbic_top_assertions.sv
// Purpose: Port-level checks for the reading buffer controller
// Assumes: One clock, synchronous active-high reset
// Notes: Shadows CTRL and THR writes to know routing and threshold
`timescale 1ns/10ps
module rbic_top_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reading_valid,
  input wire logic [15:0] reading_data,
  input wire logic pass_end,
  input wire logic stop_trigger,
  input wire logic [1:0] first_range,
  input wire logic scan_active,
  input wire logic scan_abort,
  input wire logic [15:0] threshold_level,
  input wire logic irq_host,
  input wire logic irq_port
);
  logic [2:0] ctrl_q;
  logic [7:0] thr_q;
  logic [15:0] fs;
  logic signed [31:0] thr_exp;
  logic wr_done;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Shadow copies, updated at the same edge the slave applies a write
  assign wr_done = psel && penable && pwrite && pready;
  always @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= 3'h0;
      thr_q <= 8'h00;
    end else if (wr_done && paddr == 12'h000) begin
      ctrl_q <= pwdata[2:0];
    end else if (wr_done && paddr == 12'h020) begin
      thr_q <= pwdata[7:0];
    end
  end
  // Full scale code per range; percent is sign extended before the product
  always @* begin
    case (first_range)
      2'h0: fs = 16'h0028;
      2'h1: fs = 16'h0140;
      2'h2: fs = 16'h0A00;
      default: fs = 16'h2800;
    endcase
  end
  assign thr_exp = $signed({16'h0000, fs}) * $signed({{24{thr_q[7]}}, thr_q});
  ////////////////////////////////////////
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_one_wait; s_access |=> s_answer; endproperty
  property p_ready_in_access; pready |-> psel && penable; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_refuse;
    psel && penable && pready && !pwrite && paddr == 12'h010 && ctrl_q[2] |->
      pslverr && prdata == 32'h0;
  endproperty
  property p_route; ctrl_q[2] == $past(ctrl_q[2]) |-> (ctrl_q[2] ? !irq_host : !irq_port); endproperty
  property p_disarm;
    wr_done && paddr == 12'h000 && pwdata[2:0] != ctrl_q |=> ##1 (!irq_host && !irq_port) [*2];
  endproperty
  property p_reset_quiet;
    disable iff (1'b0) reset |=> !scan_active && !irq_host && !irq_port && !scan_abort;
  endproperty
  property p_abort; scan_abort |-> !scan_active ##1 !scan_abort; endproperty
  property p_threshold;
    ($stable(first_range) && $stable(thr_q)) [*2] |-> threshold_level == thr_exp[15:0];
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not one cycle after access");
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_refuse: assert property (p_refuse) else $error("fetch not refused");
  a_route: assert property (p_route) else $error("interrupt on wrong target");
  a_disarm: assert property (p_disarm) else $error("interrupt kept");
  a_reset_quiet: assert property (p_reset_quiet) else $error("output busy after reset");
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  a_threshold: assert property (p_threshold) else $error("threshold level wrong");
endmodule
bind rbic_top rbic_top_assertions u_rbic_top_assertions (.clk_sys(clk_sys), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .reading_valid(reading_valid),
  .reading_data(reading_data), .pass_end(pass_end), .stop_trigger(stop_trigger),
  .first_range(first_range), .scan_active(scan_active), .scan_abort(scan_abort),
  .threshold_level(threshold_level), .irq_host(irq_host), .irq_port(irq_port));

// file: bench/rbic_scan_model.sv
// Purpose: Scan front end feeding readings and pass ends to the buffer
// Assumes: One reading a clock, a three-cycle gap between passes
// Notes: Data lines invert every clock while idle, alternating with the last value
`timescale 1ns/10ps
module rbic_scan_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic run,
  input wire logic hold,
  input wire logic [15:0] pass_len,
  output logic reading_valid,
  output logic [15:0] reading_data,
  output logic pass_end
);
  logic [15:0] idx;
  logic [15:0] val;
  logic [1:0] gap;
  ////////////////////////////////////////
  // The gap lets the scan end at a pass boundary before more data comes
  always @(posedge clk_sys) begin
    reading_valid <= 1'b0;
    pass_end <= 1'b0;
    reading_data <= ~reading_data;
    if (reset) begin
      val <= 16'h1234;
      reading_data <= 16'h0000;
    end
    if (reset || !run) begin
      idx <= 16'h0000;
      gap <= 2'h3;
    end else if (gap != 2'h0) begin
      gap <= gap - 2'h1;
    end else if (!hold) begin
      reading_valid <= 1'b1;
      reading_data <= val;
      val <= val + 16'h0001;
      idx <= idx + 16'h0001;
      if (idx == pass_len - 16'h0001) begin
        pass_end <= 1'b1;
        idx <= 16'h0000;
        gap <= 2'h3;
      end
    end
  end
endmodule

// file: bench/tb.sv
// Purpose: Self-checking bench for the reading buffer controller
// Assumes: APB master tasks, scan model on the reading side
// Notes: The near-full pass runs a full buffer load, about 66k cycles
`timescale 1ns/10ps
module tb;
  logic clk_sys, reset, psel, penable, pwrite, stop_trigger, hold, pready, pslverr, rerr;
  logic reading_valid, pass_end, scan_active, scan_abort, irq_host, irq_port;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, seed;
  logic [15:0] reading_data, threshold_level, plen;
  logic [1:0] first_range;
  logic signed [31:0] p;
  logic [15:0] q[$];
  int n_fail, checks, npass;
  rbic_top u_rbic_top (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reading_valid, .reading_data, .pass_end, .stop_trigger, .first_range,
    .scan_active, .scan_abort, .threshold_level, .irq_host, .irq_port);
  rbic_scan_model u_rbic_scan_model (.clk_sys, .reset, .run(scan_active), .hold,
    .pass_len(plen), .reading_valid, .reading_data, .pass_end);
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Mirror of what the buffer should have stored
  always @(posedge clk_sys) begin
    if (pass_end) npass <= npass + 1;
    if (reading_valid && scan_active) q.push_back(reading_data);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] fs(input logic [1:0] r);
    return r == 2'h0 ? 16'h0028 : r == 2'h1 ? 16'h0140 : r == 2'h2 ? 16'h0A00 : 16'h2800;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      give_verdict();
    end
    @(posedge clk_sys);
  endtask
  // Waits for npass to reach n, or for the scan to end when n is zero
  task automatic wait_for(input int n);
    int k;
    k = 0;
    while ((n > 0 ? npass < n : scan_active !== 1'b0) && k < 80000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 80000) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task stop;
    stop_trigger <= 1'b1;
    @(posedge clk_sys);
    stop_trigger <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Disarm, clear the sticky data-available bit, arm again
  task rearm;
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b1, 12'h01C, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
  endtask
  task automatic run(input logic [1:0] m, input logic [31:0] s, input logic [15:0] len);
    apb(1'b1, 12'h000, {30'h0, m});
    apb(1'b1, 12'h004, s);
    apb(1'b1, 12'h01C, 32'hF);
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    plen = len;
    q.delete();
    npass = 0;
    apb(1'b1, 12'h008, 32'h4);
  endtask
  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, stop_trigger, hold, paddr, pwdata} = '0;
    first_range = 2'h3; // Fixed range while scanning
    plen = 16'h4;
    n_fail = 0;
    checks = 0;
    npass = 0;
    seed = 32'hcf28;
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, 12'h00C, 0);
    check(rdat, 0);
    apb(1'b1, 12'h040, 32'h7);
    apb(1'b0, 12'h000, 0);
    check(rdat, 0);
    // Any-reading mode: one pass, disarm keeps pending until emptied
    run(2'h0, 0, 16'h4);
    repeat (2) @(posedge clk_sys);
    stop();
    wait_for(0);
    apb(1'b0, 12'h024, 0);
    check(rdat, 4);
    check(irq_host, 1);
    rearm();
    apb(1'b0, 12'h014, 0);
    check(rdat[0], 1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h010, 0);
      check(rdat[15:0], q[i]);
    end
    rearm();
    apb(1'b1, 12'h018, 32'h3);
    apb(1'b0, 12'h014, 0);
    check(rdat[1:0], 2'h2);
    check(irq_host, 1);
    // Parallel target refuses fetches and takes the interrupt
    apb(1'b1, 12'h000, 32'h4);
    @(posedge clk_sys);
    check({irq_host, irq_port}, 0);
    apb(1'b0, 12'h010, 0);
    check(rerr, 1);
    check(rdat, 0);
    apb(1'b1, 12'h018, 32'h8);
    apb(1'b1, 12'h008, 32'h1);
    check({irq_host, irq_port}, 1);
    apb(1'b1, 12'h000, 32'h5);
    @(posedge clk_sys);
    check({irq_host, irq_port}, 0);
    // Scan-finish and trimmed-final modes
    for (int m = 2; m < 4; m++) begin
      run(m[1:0], {16'h1, 16'h1}, 16'h3);
      wait_for(2);
      check(irq_host, 0);
      apb(1'b0, 12'h00C, 0);
      check(rdat[1], m == 2);
      stop();
      wait_for(0);
      repeat (2) @(posedge clk_sys);
      check(irq_host, 1);
      apb(1'b0, 12'h024, 0);
      check(rdat, m == 2 ? q.size() : 6);
      apb(1'b0, 12'h010, 0);
      check(rdat[15:0], m == 2 ? q[0] : q[q.size() - 6]);
      rearm();
      apb(1'b0, 12'h014, 0);
      check({irq_host, rdat[0]}, 0);
    end
    // Early stop ignored below the prescan count
    run(2'h2, {16'h0, 16'h3}, 16'h3);
    repeat (6) @(posedge clk_sys);
    stop();
    wait_for(3);
    check(scan_active, 1);
    repeat (3) @(posedge clk_sys);
    stop();
    wait_for(0);
    apb(1'b0, 12'h024, 0);
    check(npass, 4);
    check(rdat, 12);
    // Threshold follows range and random percent
    for (int r = 0; r < 4; r++) begin
      seed = lfsr(seed);
      apb(1'b1, 12'h020, {{24{seed[7]}}, seed[7:0]});
      first_range <= r[1:0];
      repeat (3) @(posedge clk_sys);
      p = $signed({16'h0, fs(r[1:0])}) * $signed({{24{seed[7]}}, seed[7:0]});
      check(threshold_level, p[15:0]);
    end
    first_range <= 2'h3;
    // Near-full mode, then run on to a full-buffer abort
    run(2'h1, 0, 16'h1000);
    wait_for(14);
    check(irq_host, 0);
    wait_for(15);
    hold <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(irq_host, 1);
    apb(1'b0, 12'h024, 0);
    check(rdat, 61440);
    hold <= 1'b0;
    wait_for(0);
    apb(1'b0, 12'h024, 0);
    check(rdat, 65536);
    apb(1'b0, 12'h00C, 0);
    check(rdat[3:1], 3'h7);
    apb(1'b0, 12'h014, 0);
    check(rdat[2], 1);
    give_verdict();
  end
endmodule
